// *** core/pmsp_flash_div.sv ***
// two fixed dividers making the slow and rapid flash phases
// assumes core_clk at the package rate
module pmsp_flash_div import pmsp_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   pmsp_flash_if.src fl
);
   logic [DIV_W-1:0] slowCnt_reg;
   logic [DIV_W-1:0] fastCnt_reg;
   logic slow_reg;
   logic fast_reg;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         slowCnt_reg <= '0;
         slow_reg <= 1'b0;
      end else if (slowCnt_reg == DIV_W'(SLOW_HALF_CYC - 1)) begin
         slowCnt_reg <= '0;
         slow_reg <= ~slow_reg;
      end else begin
         slowCnt_reg <= slowCnt_reg + 1'b1;
      end
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fastCnt_reg <= '0;
         fast_reg <= 1'b0;
      end else if (fastCnt_reg == DIV_W'(FAST_HALF_CYC - 1)) begin
         fastCnt_reg <= '0;
         fast_reg <= ~fast_reg;
      end else begin
         fastCnt_reg <= fastCnt_reg + 1'b1;
      end
   end
   assign fl.slowPhase = slow_reg;
   assign fl.fastPhase = fast_reg;
endmodule : pmsp_flash_div

// *** core/pmsp_flash_if.sv ***
// carries flash phases from the divider to the panel core
// assumes one clock domain
interface pmsp_flash_if;
   logic slowPhase;
   logic fastPhase;
   modport src (output slowPhase, output fastPhase);
   modport dst (input slowPhase, input fastPhase);
endinterface : pmsp_flash_if

// *** core/pmsp_panel.sv ***
// mode switch sequencing and status indicators of the controller cpu
// assumes panel switches and fault events come from outside the clock domain
// Notes on behaviour
// - run switch runs program, run lamp lit
// - run to stop enters stop, red lamp
// - switch down: overall reset clears all ram
// - switch up: clear data, call startup block
// - midpoint: resume, keep data
// - run: run lamp on, stop off
// - external stop: stop steady, run dark
// - initial start and check: both dark
// - self stop flashes slowly until switch stop
// - overall reset pending: rapid flash
// - ack timeout lamp for listed modules or addresses in the image range
// - address error lamp on empty address
// - cycle overrun lamp on monitor expiry
// - inhibit lamp, outputs forced safe
// - port lamp lit when cannot communicate
// - second port lamp: bad submodule, params
module pmsp_panel import pmsp_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic modeRunPin,
   input wire logic [1:0] momentarySwitchPin,
   input wire logic extStopReq,
   input wire logic selfStopReq,
   input wire logic selfOresReq,
   input wire logic initDone,
   input wire logic checkDone,
   input wire logic ramClearDone,
   input wire logic ioAccess,
   input wire logic ioAck,
   input wire logic [7:0] ioByteAddr,
   input wire logic ioInPresentList,
   input wire logic ioModulePresent,
   input wire logic cycleOverrun,
   input wire logic port1Fault,
   input wire logic port2Fault,
   input wire logic port2Used,
   input wire logic port2BadSubmodule,
   input wire logic port2BadParams,
   input wire logic [7:0] digitalOutReq,
   output logic runIndicator,
   output logic stopIndicator,
   output logic ioAckTimeoutIndicator,
   output logic addressErrorIndicator,
   output logic cycleOverrunIndicator,
   output logic outputInhibit,
   output logic programmerPortOneIndicator,
   output logic secondSerialPortIndicator,
   output logic programExecute,
   output logic ramClearStart,
   output logic dataClear,
   output logic restartStartupCall,
   output logic [7:0] restartStartupBlock,
   output logic resumeProgram,
   output logic [7:0] digitalOut
);
   logic modeRun;
   logic [1:0] mom;
   logic [2:0] evSync;
   logic [4:0] portSync;
   logic modeRunPrev_reg;
   pmsp_state_t state_reg;
   pmsp_stop_t stopCause_reg;
   logic oresPending_reg;
   logic [7:0] out_reg;
   logic ackLamp_reg;
   logic addrLamp_reg;
   logic cycLamp_reg;
   logic p1Lamp_reg;
   logic p2Lamp_reg;
   logic runLamp_reg;
   logic stopLamp_reg;
   logic ramClr_reg;
   logic dataClr_reg;
   logic startupCall_reg;
   logic resume_reg;
   logic faultClear;
   logic stopToRun;
   logic runToStop;
   pmsp_flash_if flash();

   pmsp_flash_div uDiv (
      .core_clk(core_clk),
      .rst(rst),
      .fl(flash)
   );
   pmsp_sync #(.W(3)) uSwSync (
      .core_clk(core_clk),
      .rst(rst),
      .din({modeRunPin, momentarySwitchPin}),
      .dout({modeRun, mom})
   );
   pmsp_sync #(.W(3)) uEvSync (
      .core_clk(core_clk),
      .rst(rst),
      .din({extStopReq, selfStopReq, selfOresReq}),
      .dout(evSync)
   );
   pmsp_sync #(.W(5)) uPortSync (
      .core_clk(core_clk),
      .rst(rst),
      .din({port1Fault, port2Fault, port2Used, port2BadSubmodule, port2BadParams}),
      .dout(portSync)
   );

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         modeRunPrev_reg <= 1'b0;
      end else begin
         modeRunPrev_reg <= modeRun;
      end
   end
   assign stopToRun = modeRun & ~modeRunPrev_reg;
   assign runToStop = ~modeRun & modeRunPrev_reg;

   // main operating state
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= PMSP_INIT;
      end else begin
         unique case (state_reg)
            PMSP_INIT: begin
               if (initDone) begin
                  state_reg <= PMSP_STOP;
               end
            end
            PMSP_STOP: begin
               // switch held during stop to run
               if (stopToRun && oresPending_reg) begin
                  state_reg <= (mom == MOM_DOWN) ? PMSP_CLEAR : PMSP_STOP;
               end else if (stopToRun && mom == MOM_DOWN) begin
                  state_reg <= PMSP_CLEAR;
               end else if (stopToRun) begin
                  state_reg <= PMSP_CHECK;
               end
            end
            PMSP_CLEAR: begin
               // overall reset completes back to stop
               if (ramClearDone) begin
                  state_reg <= PMSP_STOP;
               end
            end
            PMSP_CHECK: begin
               if (checkDone) begin
                  state_reg <= PMSP_RUN;
               end
            end
            PMSP_RUN: begin
               if (runToStop || evSync[2] || evSync[1] || evSync[0]) begin
                  state_reg <= PMSP_STOP;
               end
            end
            default: state_reg <= PMSP_INIT;
         endcase
      end
   end

   // cause of the most recent stop
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         stopCause_reg <= STOP_EXT;
      end else if (state_reg == PMSP_RUN && (evSync[1] || evSync[0])
                   && !runToStop && !evSync[2]) begin
         stopCause_reg <= STOP_SELF;
      end else if (state_reg == PMSP_RUN && (runToStop || evSync[2])) begin
         stopCause_reg <= STOP_EXT;
      end else if (state_reg == PMSP_STOP && runToStop) begin
         // switch to stop makes it steady
         stopCause_reg <= STOP_EXT;
      end
   end

   // overall reset request: set wins over clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         oresPending_reg <= 1'b1;
      end else if (evSync[0] || (state_reg == PMSP_STOP && mom == MOM_DOWN && !modeRun)) begin
         oresPending_reg <= 1'b1;
      end else if (state_reg == PMSP_CLEAR && ramClearDone) begin
         oresPending_reg <= 1'b0;
      end
   end

   // a start command is taken only at the stop to run edge; while an
   // overall reset is pending every position but down is refused
   function automatic logic startCmd(input pmsp_state_t st, input logic edgeSeen,
                                     input logic pend, input logic [1:0] pos,
                                     input logic [1:0] want);
      startCmd = st == PMSP_STOP && edgeSeen && pos == want
                 && (!pend || want == MOM_DOWN);
   endfunction : startCmd

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ramClr_reg <= 1'b0;
      end else begin
         ramClr_reg <= startCmd(state_reg, stopToRun, oresPending_reg, mom, MOM_DOWN);
      end
   end

   // clear data and call startup block in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dataClr_reg <= 1'b0;
         startupCall_reg <= 1'b0;
      end else begin
         dataClr_reg <= startCmd(state_reg, stopToRun, oresPending_reg, mom, MOM_UP);
         startupCall_reg <= startCmd(state_reg, stopToRun, oresPending_reg, mom, MOM_UP);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         resume_reg <= 1'b0;
      end else begin
         resume_reg <= startCmd(state_reg, stopToRun, oresPending_reg, mom, MOM_MID);
      end
   end

   // run and stop lamps
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         runLamp_reg <= 1'b0;
         stopLamp_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            PMSP_RUN: begin
               runLamp_reg <= 1'b1;
               stopLamp_reg <= 1'b0;
            end
            PMSP_STOP, PMSP_CLEAR: begin
               runLamp_reg <= 1'b0;
               if (oresPending_reg) begin
                  stopLamp_reg <= flash.fastPhase;
               end else if (stopCause_reg == STOP_SELF) begin
                  stopLamp_reg <= flash.slowPhase;
               end else begin
                  stopLamp_reg <= 1'b1;
               end
            end
            default: begin
               runLamp_reg <= 1'b0;
               stopLamp_reg <= 1'b0;
            end
         endcase
      end
   end

   // ack timeout, address and overrun lamps stay lit until the next data clear or overall reset,
   // so a fault of one cycle is not lost to the operator; set wins
   assign faultClear = dataClr_reg | ramClr_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ackLamp_reg <= 1'b0;
      end else if (ioAccess && !ioAck && (ioInPresentList || ioByteAddr <= IMAGE_LAST_BYTE)) begin
         ackLamp_reg <= 1'b1;
      end else if (faultClear) begin
         ackLamp_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addrLamp_reg <= 1'b0;
      end else if (ioAccess && !ioModulePresent) begin
         addrLamp_reg <= 1'b1;
      end else if (faultClear) begin
         addrLamp_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cycLamp_reg <= 1'b0;
      end else if (cycleOverrun) begin
         cycLamp_reg <= 1'b1;
      end else if (faultClear) begin
         cycLamp_reg <= 1'b0;
      end
   end

   // serial port lamps
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         p1Lamp_reg <= 1'b0;
         p2Lamp_reg <= 1'b0;
      end else begin
         p1Lamp_reg <= portSync[4];
         p2Lamp_reg <= portSync[2] & (portSync[3] | portSync[1] | portSync[0]);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_reg <= '0;
      end else if (state_reg != PMSP_RUN) begin
         out_reg <= '0;
      end else begin
         out_reg <= digitalOutReq;
      end
   end

   assign runIndicator = runLamp_reg;
   assign stopIndicator = stopLamp_reg;
   assign ioAckTimeoutIndicator = ackLamp_reg;
   assign addressErrorIndicator = addrLamp_reg;
   assign cycleOverrunIndicator = cycLamp_reg;
   assign outputInhibit = state_reg != PMSP_RUN;
   assign programmerPortOneIndicator = p1Lamp_reg;
   assign secondSerialPortIndicator = p2Lamp_reg;
   assign programExecute = state_reg == PMSP_RUN;
   assign ramClearStart = ramClr_reg;
   assign dataClear = dataClr_reg;
   assign restartStartupCall = startupCall_reg;
   assign restartStartupBlock = STARTUP_BLOCK_NUM;
   assign resumeProgram = resume_reg;
   assign digitalOut = out_reg;
endmodule : pmsp_panel

// *** core/pmsp_pkg.sv ***
// constants and types for the cpu mode and status panel
// assumes a single 250 MHz core clock
package pmsp_pkg;
   localparam int CLK_MHZ = 250;
   localparam int SLOW_FLASH_MS = 500;
   localparam int FAST_FLASH_MS = 125;
   localparam int SLOW_HALF_CYC = SLOW_FLASH_MS * 1000 * CLK_MHZ;
   localparam int FAST_HALF_CYC = FAST_FLASH_MS * 1000 * CLK_MHZ;
   localparam int DIV_W = 27;
   localparam logic [7:0] STARTUP_BLOCK_NUM = 8'h14;
   localparam logic [7:0] IMAGE_LAST_BYTE = 8'h7F;
   localparam logic [1:0] MOM_MID = 2'h0;
   localparam logic [1:0] MOM_UP = 2'h1;
   localparam logic [1:0] MOM_DOWN = 2'h2;
   typedef enum logic [2:0] {
      PMSP_INIT = 3'h0,
      PMSP_STOP = 3'h1,
      PMSP_CHECK = 3'h3,
      PMSP_RUN = 3'h2,
      PMSP_CLEAR = 3'h6
   } pmsp_state_t;
   typedef enum logic [1:0] {
      STOP_EXT = 2'h0,
      STOP_SELF = 2'h1,
      STOP_ORES = 2'h3
   } pmsp_stop_t;
endpackage : pmsp_pkg

// *** core/pmsp_sync.sv ***
// three-stage synchroniser with second/third agreement
// assumes asynchronous panel pins
module pmsp_sync #(parameter int W = 1) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] q_reg;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         q_reg <= '0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               q_reg[i] <= s3_reg[i];
            end
         end
      end
   end
   assign dout = q_reg;
endmodule : pmsp_sync

// *** tb/pmsp_panel_partner.sv ***
// operator switches and backplane i/o modules
// assumes the bench calls its tasks just after a clock edge
module pmsp_panel_partner import pmsp_pkg::*; (
   input wire logic core_clk,
   input wire logic ioAccess,
   input wire logic [7:0] ioByteAddr,
   output logic modeRunPin,
   output logic [1:0] momentarySwitchPin,
   output logic ioAck,
   output logic ioModulePresent
);
   timeunit 1ns;
   timeprecision 1ps;
   logic deadModule = 1'b0;
   // modules fitted in the lowest quarter only
   assign ioModulePresent = ioByteAddr < 8'h40;
   assign ioAck = ioAccess && ioModulePresent && !deadModule;
   initial begin
      modeRunPin = 1'b0;
      momentarySwitchPin = MOM_MID;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : hold
   task automatic flip(input logic [1:0] pos);
      momentarySwitchPin = pos;
      hold(8);
      modeRunPin = 1'b1;
      hold(8);
      momentarySwitchPin = MOM_MID;
   endtask : flip
   task automatic toStop();
      modeRunPin = 1'b0;
      hold(10);
   endtask : toStop
endmodule : pmsp_panel_partner

// *** tb/pmsp_panel_sva.sv ***
// port assertions for the mode and status panel
// assumes one core_clk domain, bound onto pmsp_panel
module pmsp_panel_sva (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ioAccess,
   input wire logic ioModulePresent,
   input wire logic cycleOverrun,
   input wire logic runIndicator,
   input wire logic stopIndicator,
   input wire logic addressErrorIndicator,
   input wire logic cycleOverrunIndicator,
   input wire logic outputInhibit,
   input wire logic programExecute,
   input wire logic ramClearStart,
   input wire logic dataClear,
   input wire logic restartStartupCall,
   input wire logic [7:0] restartStartupBlock,
   input wire logic resumeProgram,
   input wire logic [7:0] digitalOut
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_runLamp; runIndicator == $past(programExecute); endproperty
   a_runLamp: assert property (p_runLamp) else $error("run lamp off");
   property p_oneLamp; runIndicator |-> !stopIndicator; endproperty
   a_oneLamp: assert property (p_oneLamp) else $error("both lamps");
   property p_inhibit; outputInhibit == !programExecute; endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibit wrong");
   property p_safe; outputInhibit && $past(outputInhibit) |-> digitalOut == 8'h00; endproperty
   a_safe: assert property (p_safe) else $error("outputs not safe");
   property p_call; dataClear |-> restartStartupCall && restartStartupBlock == 8'h14; endproperty
   a_call: assert property (p_call) else $error("startup call");
   property p_dark; dataClear |=> !runIndicator && !stopIndicator; endproperty
   a_dark: assert property (p_dark) else $error("check lamps lit");
   property p_keep; resumeProgram |-> !dataClear && !ramClearStart; endproperty
   a_keep: assert property (p_keep) else $error("restart cleared");
   property p_ovr; cycleOverrun |-> ##[1:3] cycleOverrunIndicator; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun lamp");
   property p_addr; ioAccess && !ioModulePresent |-> ##[1:3] addressErrorIndicator; endproperty
   a_addr: assert property (p_addr) else $error("address lamp");
   cover property (ramClearStart);
   cover property (resumeProgram);
   cover property (dataClear);
endmodule : pmsp_panel_sva
bind pmsp_panel pmsp_panel_sva chk (.core_clk, .rst, .ioAccess, .ioModulePresent, .cycleOverrun,
   .runIndicator, .stopIndicator, .addressErrorIndicator, .cycleOverrunIndicator, .outputInhibit,
   .programExecute, .ramClearStart, .dataClear, .restartStartupCall, .restartStartupBlock,
   .resumeProgram, .digitalOut);

// *** tb/tb_top.sv ***
// self-checking bench for the mode and status panel
// assumes the partner model for switches and i/o
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import pmsp_pkg::*;
   logic core_clk, rst, extStopReq, selfStopReq, selfOresReq, initDone, checkDone;
   logic ramClearDone, ioAccess, ioAck, ioInPresentList, ioModulePresent, cycleOverrun;
   logic port1Fault, port2Fault, port2Used, port2BadSubmodule, port2BadParams, modeRunPin;
   logic runIndicator, stopIndicator, ioAckTimeoutIndicator, addressErrorIndicator;
   logic cycleOverrunIndicator, outputInhibit, programmerPortOneIndicator, programExecute;
   logic secondSerialPortIndicator, ramClearStart, dataClear, restartStartupCall, resumeProgram;
   logic [1:0] momentarySwitchPin;
   logic [7:0] ioByteAddr, digitalOutReq, restartStartupBlock, digitalOut;
   int miscompares = 0, nTests = 0, sawClear = 0, sawCall = 0, sawRam = 0, sawResume = 0;
   pmsp_panel DUT (.core_clk, .rst, .modeRunPin, .momentarySwitchPin, .extStopReq,
      .selfStopReq, .selfOresReq, .initDone, .checkDone, .ramClearDone, .ioAccess, .ioAck,
      .ioByteAddr, .ioInPresentList, .ioModulePresent, .cycleOverrun, .port1Fault,
      .port2Fault, .port2Used, .port2BadSubmodule, .port2BadParams, .digitalOutReq,
      .runIndicator, .stopIndicator, .ioAckTimeoutIndicator, .addressErrorIndicator,
      .cycleOverrunIndicator, .outputInhibit, .programmerPortOneIndicator,
      .secondSerialPortIndicator, .programExecute, .ramClearStart, .dataClear,
      .restartStartupCall, .restartStartupBlock, .resumeProgram, .digitalOut);
   pmsp_panel_partner op (.core_clk, .ioAccess, .ioByteAddr, .modeRunPin,
      .momentarySwitchPin, .ioAck, .ioModulePresent);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (dataClear === 1'b1) sawClear++;
      if (restartStartupCall === 1'b1) sawCall++;
      if (ramClearStart === 1'b1) sawRam++;
      if (resumeProgram === 1'b1) sawResume++;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic pulse(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask : pulse
   task automatic waitFor(ref int c);
      for (int i = 0; i < 60 && c == 0; i++) cyc(1);
   endtask : waitFor
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      nTests++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic conclude();
      $display("compares %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   task automatic tPowerUp();
      cyc(3);
      chk("stopLamp", 0, stopIndicator);
      chk("inhibit", 1, outputInhibit);
      pulse(initDone);
      // pending overall reset refuses a plain reset
      op.flip(MOM_UP);
      chk("clears", 0, sawClear[7:0]);
      chk("runLamp", 0, runIndicator);
      op.toStop();
      op.flip(MOM_DOWN);
      waitFor(sawRam);
      chk("ramClear", 1, sawRam[7:0]);
      pulse(ramClearDone);
      cyc(2);
      chk("stopLamp", 1, stopIndicator);
      chk("faults", 0, {ioAckTimeoutIndicator, addressErrorIndicator});
   endtask : tPowerUp
   task automatic tResetRun();
      op.toStop();
      op.flip(MOM_UP);
      waitFor(sawClear);
      chk("calls", 1, sawCall[7:0]);
      chk("block", 8'h14, restartStartupBlock);
      chk("runLamp", 0, runIndicator);
      pulse(checkDone);
      cyc(2);
      chk("runLamp", 1, runIndicator);
      chk("stopLamp", 0, stopIndicator);
      digitalOutReq = 8'hA5;
      cyc(2);
      chk("outputs", 8'hA5, digitalOut);
      // beyond the image range and not listed: no timeout lamp
      ioAccess = 1'b1;
      ioByteAddr = 8'h90;
      cyc(1);
      ioAccess = 1'b0;
      cyc(1);
      chk("ackLamp", 0, ioAckTimeoutIndicator);
      op.deadModule = 1'b1;
      ioAccess = 1'b1;
      ioByteAddr = 8'h10;
      cyc(1);
      ioByteAddr = 8'h50;
      cyc(1);
      ioAccess = 1'b0;
      op.deadModule = 1'b0;
      pulse(cycleOverrun);
      cyc(3);
      chk("ackLamp", 1, ioAckTimeoutIndicator);
      chk("addrLamp", 1, addressErrorIndicator);
      chk("ovrLamp", 1, cycleOverrunIndicator);
   endtask : tResetRun
   task automatic tStops();
      op.toStop();
      chk("stopLamp", 1, stopIndicator);
      chk("outputs", 8'h00, digitalOut);
      op.flip(MOM_MID);
      waitFor(sawResume);
      chk("clears", 1, sawClear[7:0]);
      chk("addrLamp", 1, addressErrorIndicator);
      pulse(checkDone);
      selfStopReq = 1'b1;
      cyc(8);
      selfStopReq = 1'b0;
      chk("runLamp", 0, runIndicator);
      // slow phase starts dark, so the lamp is not steady here
      chk("stopLamp", 0, stopIndicator);
      op.toStop();
      chk("stopLamp", 1, stopIndicator);
      op.flip(MOM_MID);
      pulse(checkDone);
      extStopReq = 1'b1;
      cyc(8);
      extStopReq = 1'b0;
      chk("runLamp", 0, runIndicator);
      chk("stopLamp", 1, stopIndicator);
   endtask : tStops
   task automatic tPorts();
      logic [4:0] v [6] = '{5'h00, 5'h10, 5'h0C, 5'h08, 5'h06, 5'h05};
      foreach (v[i]) begin
         {port1Fault, port2Fault, port2Used, port2BadSubmodule, port2BadParams} = v[i];
         cyc(8);
         chk("port1", 8'(v[i][4]), programmerPortOneIndicator);
         chk("port2", 8'(v[i][2] & |{v[i][3], v[i][1:0]}), secondSerialPortIndicator);
      end
   endtask : tPorts
   initial begin
      rst = 1'b1;
      {extStopReq, selfStopReq, selfOresReq, initDone, checkDone, ramClearDone} = '0;
      {ioAccess, ioInPresentList, cycleOverrun, port1Fault, port2Fault, port2Used} = '0;
      {port2BadSubmodule, port2BadParams} = '0;
      ioByteAddr = 8'h00;
      digitalOutReq = 8'h00;
      cyc(12);
      rst = 1'b0;
      tPowerUp();
      tResetRun();
      tStops();
      tPorts();
      conclude();
   end
   // the sequence needs well under 1000 cycles
   initial begin
      #20000;
      miscompares++;
      conclude();
   end
endmodule : tb_top
